// file: core/acr_pkg.sv
// constants and types shared by the amplifier control register bank
package acr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ACR_OFS_CHIP_ID = 8'h00;
  localparam logic [7:0] ACR_OFS_POWER = 8'h01;
  localparam logic [7:0] ACR_OFS_DIGITAL = 8'h02;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] ACR_RST_POWER = 8'hFD;
  localparam logic [7:0] ACR_RST_DIGITAL = 8'h14;
  // identification value is arbitrary, not tied to any real part
  localparam logic [7:0] ACR_CHIP_ID_DEF = 8'h3A;
  // default 7-bit target address on the control bus
  localparam logic [6:0] ACR_TARGET_ADDR_DEF = 7'h6C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ACR_PWR_CLIP_HI = 7;
  localparam int ACR_PWR_CLIP_LO = 2;
  localparam int ACR_PWR_SLEEP = 1;
  localparam int ACR_PWR_SD_N = 0;
  localparam int ACR_DIG_HPF_SKIP = 7;
  localparam int ACR_DIG_RSVD = 6;
  localparam int ACR_DIG_BOOST_HI = 5;
  localparam int ACR_DIG_BOOST_LO = 4;
  localparam int ACR_DIG_RATE = 3;
  localparam int ACR_DIG_FMT_HI = 2;
  localparam int ACR_DIG_FMT_LO = 0;
  // writable bits of the digital control register
  localparam logic [7:0] ACR_DIG_WMASK = 8'hBF;

  // ---------------------------------------------------------------
  // serial framing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] ACR_BITS_PER_BYTE = 4'h8;

  // target state machine
  typedef enum logic [3:0] {
    ACR_IDLE,
    ACR_ADDR,
    ACR_ADDR_ACK,
    ACR_WRITE,
    ACR_WRITE_ACK,
    ACR_READ,
    ACR_READ_ACK,
    ACR_READ_NEXT
  } acr_state_e;

endpackage

// file: core/acr_edge_track.sv
// registered copy and edge flags for a group of sampled bus lines
`timescale 1ns/1ps
module acr_edge_track #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // lines
  input wire logic [W-1:0] line,
  output logic [W-1:0] prev,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_q;

  // idle bus level is high, so the copy resets high to avoid a false edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prev_q <= '1;
    else if (ce)
      prev_q <= line;
  end

  // edges compare the current sample with the previous one
  assign prev = prev_q;
  assign rise = line & ~prev_q;
  assign fall = ~line & prev_q;

endmodule

// file: core/acr_regs.sv
// control register bank behind a serial control target port
//
// Notes on behaviour
// - read-only 8-bit identification at offset zero; writes leave it unchanged.
// - power control bits 7:2 give the top six of the 20-bit clip threshold.
// - sleep bit one disables power stage, keeps low-voltage blocks standby; resets zero.
// - shutdown bit active low; zero powers both domains down; resets one.
// - digital control bit 7 set bypasses the digital high-pass filter; default in path.
// - digital control bit 6 reserved, reads zero; host must leave it alone.
// - boost bits 5:4 add 0, 6, 12 or 18 dB; reset value 01.
// - rate bit 3 zero selects 32/44.1/48 kHz, one selects 88.2/96 kHz.
// - format codes 000..011 select right-justified 24, 20, 18, 16 bits.
// - format 100 selects standard framing (reset); 101 left-justified 16-24 bits.
// - write is start, address with write bit, register byte, data byte, stop; all acked.
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = ACR_TARGET_ADDR_DEF,
  parameter logic [7:0] CHIP_ID = ACR_CHIP_ID_DEF
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // control bus pins, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // power controls
  output logic [5:0] clip_threshold_high,
  output logic amp_sleep,
  output logic amp_shutdown_n,
  output logic power_stage_en,
  output logic low_voltage_en,
  // digital path controls
  output logic highpass_skip,
  output logic [1:0] boost_select,
  output logic rate_range_select,
  output logic [2:0] input_format
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    acr_state_e st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic have_ptr;
    logic rw;
    logic sda_low;
    logic [7:0] pwr;
    logic [7:0] dig;
    logic stage_en;
    logic lv_en;
  } acr_regs_s;

  acr_regs_s s_q;
  acr_regs_s s_d;

  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic unused_sda_rise;
  logic unused_sda_fall;

  // ---------------------------------------------------------------
  // line tracking
  // ---------------------------------------------------------------
  acr_edge_track #(
    .W(2)
  ) u_lines (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .line({scl_i, sda_i}),
    .prev({scl_prev, sda_prev}),
    .rise({scl_rise, unused_sda_rise}),
    .fall({scl_fall, unused_sda_fall})
  );

  // start and stop are sda moving while scl stays high
  assign bus_start = scl_i & scl_prev & sda_prev & ~sda_i;
  assign bus_stop = scl_i & scl_prev & ~sda_prev & sda_i;

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  // unmapped offsets read zero so a stray read never drives junk
  function automatic logic [7:0] rd_mux(input logic [7:0] ofs, input acr_regs_s s);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == ACR_OFS_CHIP_ID)
      v = CHIP_ID;
    else if (ofs == ACR_OFS_POWER)
      v = s.pwr;
    else if (ofs == ACR_OFS_DIGITAL)
      v = s.dig & ACR_DIG_WMASK;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one pass per sample: edges of scl move the byte engine,
  // start and stop override whatever is in progress
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      ACR_IDLE:
      begin
        s_d.sda_low = 1'b0;
      end
      ACR_ADDR:
      begin
        if (scl_rise)
        begin
          s_d.shift = {s_q.shift[6:0], sda_i};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        else if (scl_fall && s_q.cnt == ACR_BITS_PER_BYTE)
        begin
          // only our own address is acknowledged, others are left alone
          if (s_q.shift[7:1] == TARGET_ADDR)
          begin
            s_d.rw = s_q.shift[0];
            s_d.sda_low = 1'b1;
            s_d.tx = rd_mux(s_q.ptr, s_q);
            s_d.st = ACR_ADDR_ACK;
          end
          else
            s_d.st = ACR_IDLE;
        end
      end
      ACR_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          s_d.cnt = 4'h0;
          if (s_q.rw)
          begin
            s_d.sda_low = ~s_q.tx[7];
            s_d.tx = {s_q.tx[6:0], 1'b0};
            s_d.st = ACR_READ;
          end
          else
          begin
            s_d.sda_low = 1'b0;
            s_d.have_ptr = 1'b0;
            s_d.st = ACR_WRITE;
          end
        end
      end
      ACR_WRITE:
      begin
        if (scl_rise)
        begin
          s_d.shift = {s_q.shift[6:0], sda_i};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        else if (scl_fall && s_q.cnt == ACR_BITS_PER_BYTE)
        begin
          s_d.sda_low = 1'b1;
          s_d.st = ACR_WRITE_ACK;
          if (!s_q.have_ptr)
          begin
            s_d.ptr = s_q.shift;
            s_d.have_ptr = 1'b1;
          end
          else
          begin
            // identification and unmapped offsets drop the data byte
            if (s_q.ptr == ACR_OFS_POWER)
              s_d.pwr = s_q.shift;
            else if (s_q.ptr == ACR_OFS_DIGITAL)
              s_d.dig = s_q.shift & ACR_DIG_WMASK;
            s_d.ptr = s_q.ptr + 8'h01;
          end
        end
      end
      ACR_WRITE_ACK:
      begin
        if (scl_fall)
        begin
          s_d.sda_low = 1'b0;
          s_d.cnt = 4'h0;
          s_d.st = ACR_WRITE;
        end
      end
      ACR_READ:
      begin
        if (scl_rise)
          s_d.cnt = s_q.cnt + 4'h1;
        else if (scl_fall)
        begin
          if (s_q.cnt == ACR_BITS_PER_BYTE)
          begin
            // let go of sda so the host can answer
            s_d.sda_low = 1'b0;
            s_d.st = ACR_READ_ACK;
          end
          else
          begin
            s_d.sda_low = ~s_q.tx[7];
            s_d.tx = {s_q.tx[6:0], 1'b0};
          end
        end
      end
      ACR_READ_ACK:
      begin
        if (scl_rise)
        begin
          s_d.ptr = s_q.ptr + 8'h01;
          // a not-acknowledge ends the read; wait for stop in idle
          s_d.st = sda_i ? ACR_IDLE : ACR_READ_NEXT;
        end
      end
      ACR_READ_NEXT:
      begin
        if (scl_fall)
        begin
          s_d.tx = {rd_mux(s_q.ptr, s_q)};
          s_d.sda_low = ~s_d.tx[7];
          s_d.tx = {s_d.tx[6:0], 1'b0};
          s_d.cnt = 4'h0;
          s_d.st = ACR_READ;
        end
      end
      default:
      begin
        s_d.st = ACR_IDLE;
      end
    endcase

    // framing conditions win over the byte engine
    if (bus_start)
    begin
      s_d.st = ACR_ADDR;
      s_d.cnt = 4'h0;
      s_d.sda_low = 1'b0;
    end
    else if (bus_stop)
    begin
      s_d.st = ACR_IDLE;
      s_d.sda_low = 1'b0;
    end

    // power stage runs only when awake and not shut down
    s_d.stage_en = s_d.pwr[ACR_PWR_SD_N] & ~s_d.pwr[ACR_PWR_SLEEP];
    // low-voltage blocks stay up in sleep, drop only in shutdown
    s_d.lv_en = s_d.pwr[ACR_PWR_SD_N];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.st <= ACR_IDLE;
      s_q.pwr <= ACR_RST_POWER;
      s_q.dig <= ACR_RST_DIGITAL;
      s_q.stage_en <= 1'b1;
      s_q.lv_en <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // outputs, all but sda_o straight from the state register
  // ---------------------------------------------------------------
  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe = s_q.sda_low;
  assign clip_threshold_high = s_q.pwr[ACR_PWR_CLIP_HI:ACR_PWR_CLIP_LO];
  assign amp_sleep = s_q.pwr[ACR_PWR_SLEEP];
  assign amp_shutdown_n = s_q.pwr[ACR_PWR_SD_N];
  assign power_stage_en = s_q.stage_en;
  assign low_voltage_en = s_q.lv_en;
  assign highpass_skip = s_q.dig[ACR_DIG_HPF_SKIP];
  assign boost_select = s_q.dig[ACR_DIG_BOOST_HI:ACR_DIG_BOOST_LO];
  assign rate_range_select = s_q.dig[ACR_DIG_RATE];
  assign input_format = s_q.dig[ACR_DIG_FMT_HI:ACR_DIG_FMT_LO];

endmodule

// file: test/acr_chk.sv
// concurrent checks on the control register bank pins
`timescale 1ns/1ps
module acr_chk (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // control outputs
  input wire logic [5:0] clip_threshold_high,
  input wire logic amp_sleep,
  input wire logic amp_shutdown_n,
  input wire logic power_stage_en,
  input wire logic low_voltage_en,
  input wire logic highpass_skip,
  input wire logic [1:0] boost_select,
  input wire logic rate_range_select,
  input wire logic [2:0] input_format
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // reset values seen at the first edge after release
  a_power_reset_val: assert property ($rose(resetn) |->
    clip_threshold_high == 6'h3F && !amp_sleep && amp_shutdown_n) else $error("power reset");
  a_digital_reset_val: assert property ($rose(resetn) |->
    boost_select == 2'b01 && input_format == 3'b100 && !highpass_skip
    && !rate_range_select) else $error("digital reset");
  a_stage_gate: assert property (
    power_stage_en == (amp_shutdown_n && !amp_sleep)) else $error("power stage");
  a_low_volt_gate: assert property (
    low_voltage_en == amp_shutdown_n) else $error("low voltage");
  // controls only move in the scl low phase after a data byte
  a_ctrl_scl_low: assert property ($changed({clip_threshold_high, amp_sleep,
    amp_shutdown_n, highpass_skip, boost_select, rate_range_select, input_format})
    |-> !scl_i) else $error("control moved with scl high");
  a_sda_drive_low: assert property (sda_o == 1'b0) else $error("sda driven high");
  a_ack_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda moved with scl high");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i ##1 sda_oe)
    else $error("ack launch");
  a_ack_release: assert property (sda_oe |-> ##[1:100] !sda_oe)
    else $error("sda never released");
  cover property ($fell(power_stage_en));
  cover property ($changed(input_format));
  cover property ($rose(sda_oe) ##[1:60] !sda_oe);
endmodule
bind acr_regs acr_chk u_chk (.clk, .resetn, .ce, .scl_i, .sda_i, .sda_o, .sda_oe,
  .clip_threshold_high, .amp_sleep, .amp_shutdown_n, .power_stage_en, .low_voltage_en,
  .highpass_skip, .boost_select, .rate_range_select, .input_format);

// file: test/acr_host.sv
// control bus host model: drives scl and pulls sda low
`timescale 1ns/1ps
module acr_host (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one bit; sda moves mid low phase, away from scl edges
  task automatic bt(input logic b, output logic r);
    @(negedge clk);
    sda_pull = !b;
    @(negedge clk);
    scl = 1'b1;
    @(negedge clk);
    @(negedge clk);
    r = sda;
    scl = 1'b0;
  endtask
  // byte msb first, then the ninth bit (1 releases sda)
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    for (int i = 7; i >= 0; i--)
      bt(d[i], q[i]);
    bt(a, k);
  endtask
  // start, also usable as a repeated start from scl low
  task automatic st();
    @(negedge clk);
    sda_pull = 1'b0;
    @(negedge clk);
    scl = 1'b1;
    @(negedge clk);
    sda_pull = 1'b1;
    @(negedge clk);
    scl = 1'b0;
  endtask
  task automatic sp();
    @(negedge clk);
    sda_pull = 1'b1;
    @(negedge clk);
    scl = 1'b1;
    @(negedge clk);
    sda_pull = 1'b0;
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb
  import acr_pkg::*;
;
  localparam logic [6:0] ADDR = ACR_TARGET_ADDR_DEF;
  logic clk, resetn, ce, scl_i, pull, sda_i, sda_oe;
  logic [9:0] pwr_pins;
  logic [6:0] dig_pins;
  logic [5:0] clip_threshold_high;
  logic amp_sleep, amp_shutdown_n, power_stage_en, low_voltage_en;
  logic highpass_skip, rate_range_select;
  logic [1:0] boost_select;
  logic [2:0] input_format;
  logic [7:0] q, v;
  logic k;
  int failures = 0;
  int samples_checked = 0;
  // pull-up on sda; either side may pull it low
  assign sda_i = !(pull || sda_oe);
  // grouped control pins keep the compare lines short
  assign pwr_pins = {clip_threshold_high, amp_sleep, amp_shutdown_n, power_stage_en,
    low_voltage_en};
  assign dig_pins = {highpass_skip, boost_select, rate_range_select, input_format};
  acr_regs uut (.clk, .resetn, .ce, .scl_i, .sda_i, .sda_o(), .sda_oe,
    .clip_threshold_high, .amp_sleep, .amp_shutdown_n, .power_stage_en, .low_voltage_en,
    .highpass_skip, .boost_select, .rate_range_select, .input_format);
  acr_host h (.clk, .sda(sda_i), .scl(scl_i), .sda_pull(pull));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] x;
    logic a;
    h.st();
    h.xb({ADDR, 1'b0}, 1'b1, x, a);
    `CHK(a, 1'b0)
    h.xb(r, 1'b1, x, a);
    `CHK(a, 1'b0)
    h.xb(d, 1'b1, x, a);
    `CHK(a, 1'b0)
    h.sp();
  endtask
  // pointer write, repeated start, one byte then nack
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] x;
    logic a;
    h.st();
    h.xb({ADDR, 1'b0}, 1'b1, x, a);
    h.xb(r, 1'b1, x, a);
    h.st();
    h.xb({ADDR, 1'b1}, 1'b1, x, a);
    `CHK(a, 1'b0)
    h.xb(8'hFF, 1'b1, d, a);
    h.sp();
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // whole run is some 44 us; a hang is cut at 200 us
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
  initial
  begin
    ce = 1'b1;
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    `CHK(pwr_pins, 10'h3F7)
    rd(8'h00, q);
    `CHK(q, ACR_CHIP_ID_DEF)
    rd(8'h01, q);
    `CHK(q, ACR_RST_POWER)
    rd(8'h02, q);
    `CHK(q, ACR_RST_DIGITAL)
    wr(8'h00, 8'h55);
    rd(8'h00, q);
    `CHK(q, ACR_CHIP_ID_DEF)
    rd(8'h05, q);
    `CHK(q, 8'h00)
    // every sleep and shutdown pairing
    for (int j = 0; j < 4; j++)
    begin
      v = {j[0] ? 6'h15 : 6'h2A, j[1:0]};
      wr(8'h01, v);
      `CHK({clip_threshold_high, amp_sleep, amp_shutdown_n}, v)
      `CHK({power_stage_en, low_voltage_en}, {v[0] & ~v[1], v[0]})
      rd(8'h01, q);
      `CHK(q, v)
    end
    // formats 000..101 only, all boost steps, both rate ranges
    for (int i = 0; i < 6; i++)
    begin
      v = {i[0], 1'b0, i[1:0], ~i[0], i[2:0]};
      wr(8'h02, v);
      `CHK(dig_pins, {v[7], v[5:0]})
      rd(8'h02, q);
      `CHK(q, v)
    end
    wr(8'h02, 8'h7D);
    rd(8'h02, q);
    `CHK(q, 8'h3D)
    // a foreign target address is not acked and changes nothing
    h.st();
    h.xb({ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
    `CHK(k, 1'b1)
    h.xb(8'h01, 1'b1, q, k);
    h.xb(8'h00, 1'b1, q, k);
    h.sp();
    // a frozen block misses a whole frame addressed to it
    @(negedge clk);
    ce = 1'b0;
    h.st();
    h.xb({ADDR, 1'b0}, 1'b1, q, k);
    `CHK(k, 1'b1)
    h.xb(8'h01, 1'b1, q, k);
    h.xb(8'h00, 1'b1, q, k);
    h.sp();
    ce = 1'b1;
    rd(8'h01, q);
    `CHK(q, 8'h57)
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    `CHK(dig_pins, 7'h14)
    `CHK(pwr_pins, 10'h3F7)
    rd(8'h02, q);
    `CHK(q, ACR_RST_DIGITAL)
    end_of_test();
  end
endmodule
